// File: src/ect_pkg.sv
// Package for the edge counter timer: register map, fields, reset values.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package ect_pkg;
  // Byte offsets of the register words
  localparam logic [4:0] ECT_CTRL_OFS  = 5'h00;
  localparam logic [4:0] ECT_LOAD_OFS  = 5'h04;
  localparam logic [4:0] ECT_COUNT_OFS = 5'h08;
  localparam logic [4:0] ECT_CMD_OFS   = 5'h0C;
  localparam logic [4:0] ECT_STAT_OFS  = 5'h10;
  localparam logic [4:0] ECT_IEN_OFS   = 5'h14;
  localparam logic [4:0] ECT_ICLR_OFS  = 5'h18;
  localparam logic [4:0] ECT_STATE_OFS = 5'h1C;
  // Control field positions
  localparam int ECT_CTRL_W    = 6;
  localparam int ECT_C_UP      = 0;
  localparam int ECT_C_FALL    = 1;
  localparam int ECT_C_GATE    = 2;
  localparam int ECT_C_GLOW    = 3;
  localparam int ECT_C_TOGGLE  = 4;
  localparam int ECT_C_EXTDIR  = 5;
  localparam logic [ECT_CTRL_W-1:0] ECT_CTRL_RST = 6'h00;
  // Command bits
  localparam int ECT_K_LOAD    = 0;
  localparam int ECT_K_ARM     = 1;
  localparam int ECT_K_DISARM  = 2;
  // Status bits: terminal count reached, gate opened
  localparam int ECT_ST_W      = 2;
  localparam int ECT_S_TC      = 0;
  localparam int ECT_S_GATE    = 1;
  localparam logic [ECT_ST_W-1:0] ECT_ST_RST = 2'h0;
  // State word bits
  localparam int ECT_R_ARMED   = 0;
  localparam int ECT_R_PIN     = 1;
  localparam int ECT_R_GATE    = 2;
  localparam int ECT_R_DIR     = 3;
  // Default count width
  localparam int ECT_CNT_W     = 32;
endpackage

// File: src/ect_evt_if.sv
// Interface carrying synchronised edge and level events between modules.
// Assumes one clock; producer is the input synchroniser.
`timescale 1ns/10ps
interface ect_evt_if;
  logic src_rise; // One-cycle pulse, source rose
  logic src_fall; // One-cycle pulse, source fell
  logic gate_lvl; // Synchronised gate level
  logic dir_lvl;  // Synchronised direction line, high means up
  modport sync_mp (output src_rise, output src_fall, output gate_lvl, output dir_lvl);
  modport use_mp  (input src_rise, input src_fall, input gate_lvl, input dir_lvl);
endinterface

// File: src/ect_sync.sv
// Input synchroniser for the source, gate and direction pins; edge detector for the source.
// Assumes pins may be asynchronous to core_clk.
`timescale 1ns/10ps
module ect_sync (
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  input  wire logic  src_pin,
  input  wire logic  gate_pin,
  input  wire logic  dir_pin,
  ect_evt_if.sync_mp evt
);
  import ect_pkg::*;
  // First stage is read only by the second stage
  typedef struct packed {
    logic [2:0] s; // Source stages, s[2] is the edge history
    logic [1:0] g; // Gate stages
    logic [1:0] d; // Direction stages
  } ect_sync_st_t;
  ect_sync_st_t q_reg, q_next;

  // Shift all chains by one stage
  always_comb begin
    q_next   = q_reg;
    q_next.s = {q_reg.s[1:0], src_pin};
    q_next.g = {q_reg.g[0], gate_pin};
    q_next.d = {q_reg.d[0], dir_pin};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign evt.src_rise = q_reg.s[1] & ~q_reg.s[2];
  assign evt.src_fall = ~q_reg.s[1] & q_reg.s[2];
  assign evt.gate_lvl = q_reg.g[1];
  assign evt.dir_lvl  = q_reg.d[1];

  // Each transition yields one single-cycle pulse
  edge_once_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    evt.src_rise |=> !evt.src_rise && !evt.src_fall)
    else $error("source edge pulse lasted more than one cycle");
endmodule

// File: src/ect_outgen.sv
// Output pin generator: pulse or toggle on terminal count.
// Assumes src_edge marks each selected-polarity source edge.
`timescale 1ns/10ps
module ect_outgen (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic src_edge,
  input  wire logic tc_hit,
  input  wire logic toggle_mode,
  input  wire logic out_clr,
  output logic      pin
);
  import ect_pkg::*;
  typedef struct packed {
    logic tgl;   // Toggle level
    logic pulse; // Pulse level
  } ect_out_st_t;
  ect_out_st_t q_reg, q_next;

  // Next pin state; terminal count wins over the pulse end
  always_comb begin
    q_next = q_reg;
    if (out_clr) begin
      q_next = '0;
    end else if (tc_hit && toggle_mode) begin
      q_next.tgl = ~q_reg.tgl;
    end else if (tc_hit) begin
      q_next.pulse = 1'b1;
    end else if (src_edge) begin
      // Next source edge ends the pulse, giving one source period
      q_next.pulse = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign pin = toggle_mode ? q_reg.tgl : q_reg.pulse;

  toggle_flip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tc_hit && toggle_mode && !out_clr |=> q_reg.tgl != $past(q_reg.tgl))
    else $error("toggle output did not invert on terminal count");
  pulse_width_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tc_hit && !toggle_mode && !out_clr ##1 (!src_edge && !out_clr && !tc_hit)
      |=> q_reg.pulse)
    else $error("pulse ended before the next source edge");
endmodule

// File: src/ect_top.sv
// Edge counter timer top: Avalon-MM register slave, counter core, output pin.
// Assumes synchronous bus master, external TTL source/gate/direction pins.
//
// Contract
// - Only counted source edges advance count
// - Count register preloadable before counting
// - Each counted edge adds or subtracts one
// - Count reflects edges; reading leaves it
// - Gate qualifies counting; ungated software start
// - Output pin pulses or toggles at trigger
// - Terminal count: all ones up, zero down
// - Pulse lasts one source period
// - Toggle inverts pin each trigger
// - Terminal count output allows chaining counters
// - Rising or falling source edge selectable
// - Width parameter: 32, 24 or 16
// - External line may select count direction
// - Reduced variant counts rising edges only
// - Reduced variant: 16 bits, down only
// - Reduced variant: high-level gating only
// - Reduced variant pulse is active low
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module ect_top #(
  parameter int CNT_W   = ect_pkg::ECT_CNT_W, // Count width
  parameter bit REDUCED = 1'b0                // Reduced variant
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        src_pin,
  input  wire logic        gate_pin,
  input  wire logic        dir_pin,
  output logic             cnt_out,
  output logic             terminal_count,
  output logic             irq
);
  import ect_pkg::*;

  initial begin
    if (!(CNT_W == 32 || CNT_W == 24 || CNT_W == 16)) begin
      $error("CNT_W must be 32, 24 or 16");
    end
    if (REDUCED && CNT_W != 16) begin
      $error("reduced variant needs CNT_W of 16");
    end
  end

  // Reset release synchroniser; assertion is asynchronous
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // All block state but the reset synchroniser in one word
  typedef struct packed {
    logic                  ack;    // Second cycle of a bus access
    logic [31:0]           rdata;  // Captured read data
    logic [ECT_CTRL_W-1:0] ctrl;   // Mode control
    logic [CNT_W-1:0]      load;   // Preload value
    logic [CNT_W-1:0]      cnt;    // Live count
    logic                  armed;  // Software start
    logic                  gate_d; // Gate active, previous cycle
    logic [ECT_ST_W-1:0]   status; // Sticky events
    logic [ECT_ST_W-1:0]   ien;    // Interrupt enables
    logic                  tc_p;   // Terminal count pulse
  } ect_top_st_t;
  ect_top_st_t q_reg, q_next;

  ect_evt_if evt ();        // Synchronised pin events
  logic      pin_lvl;       // Output generator level
  logic      sel_edge;      // Selected polarity edge
  logic      gate_act;      // Gate in active state
  logic      cnt_ok;        // Counting allowed
  logic      cnt_edge;      // Edge to count this cycle
  logic      up;            // Effective direction
  logic      toggle_eff;    // Effective output mode
  logic      tc_hit;        // Counted edge steps count to terminal this cycle
  logic      load_cmd;      // Preload strobe
  logic      do_wr;         // Write takes effect
  logic      do_rd;         // Read data captured
  logic [CNT_W-1:0] tc_val; // Terminal value for direction
  logic [CNT_W-1:0] cnt_inc; // Stepped count

  // Decode one register offset
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pin synchroniser and edge detector
  ect_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .src_pin  (src_pin),
    .gate_pin (gate_pin),
    .dir_pin  (dir_pin),
    .evt      (evt.sync_mp)
  );

  // Effective mode: reduced variant overrides control bits
  always_comb begin
    sel_edge = (q_reg.ctrl[ECT_C_FALL] && !REDUCED) ? evt.src_fall : evt.src_rise;
    if (REDUCED) begin
      gate_act = evt.gate_lvl;
    end else begin
      gate_act = evt.gate_lvl ^ q_reg.ctrl[ECT_C_GLOW];
    end
    cnt_ok = q_reg.armed && (gate_act || (!q_reg.ctrl[ECT_C_GATE] && !REDUCED));
    cnt_edge = sel_edge && cnt_ok;
    if (REDUCED) begin
      up = 1'b0;
    end else if (q_reg.ctrl[ECT_C_EXTDIR]) begin
      up = evt.dir_lvl;
    end else begin
      up = q_reg.ctrl[ECT_C_UP];
    end
    toggle_eff = q_reg.ctrl[ECT_C_TOGGLE] && !REDUCED;
  end

  // Bus timing: first cycle waits, second cycle answers
  assign do_rd    = avs_read && !q_reg.ack;
  assign do_wr    = avs_write && q_reg.ack;
  assign load_cmd = do_wr && hit(avs_address, ECT_CMD_OFS) && avs_writedata[ECT_K_LOAD];
  assign tc_val   = up ? {CNT_W{1'b1}} : '0;
  assign cnt_inc  = up ? q_reg.cnt + CNT_W'(1) : q_reg.cnt - CNT_W'(1);
  assign tc_hit   = cnt_edge && !load_cmd && (cnt_inc == tc_val);

  // Next state of registers and counter
  always_comb begin
    q_next      = q_reg;
    q_next.tc_p = tc_hit;
    q_next.ack  = (avs_read || avs_write) && !q_reg.ack;
    q_next.gate_d = gate_act;
    // Read capture; reading never alters the count
    if (do_rd) begin
      case (avs_address)
        ECT_CTRL_OFS:  q_next.rdata = 32'(q_reg.ctrl);
        ECT_LOAD_OFS:  q_next.rdata = 32'(q_reg.load);
        ECT_COUNT_OFS: q_next.rdata = 32'(q_reg.cnt);
        ECT_STAT_OFS:  q_next.rdata = 32'(q_reg.status);
        ECT_IEN_OFS:   q_next.rdata = 32'(q_reg.ien);
        ECT_STATE_OFS: q_next.rdata = 32'({up, gate_act, pin_lvl, q_reg.armed});
        default:       q_next.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; unmapped offsets are ignored
    if (do_wr) begin
      case (avs_address)
        ECT_CTRL_OFS: q_next.ctrl = avs_writedata[ECT_CTRL_W-1:0];
        ECT_LOAD_OFS: q_next.load = avs_writedata[CNT_W-1:0];
        ECT_IEN_OFS:  q_next.ien  = avs_writedata[ECT_ST_W-1:0];
        ECT_CMD_OFS: begin
          if (avs_writedata[ECT_K_ARM]) begin
            q_next.armed = 1'b1;
          end
          // Disarm wins when both bits are written
          if (avs_writedata[ECT_K_DISARM]) begin
            q_next.armed = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (load_cmd) begin
      q_next.cnt = q_reg.load;
    end else if (cnt_edge) begin
      q_next.cnt = cnt_inc;
    end
    // Clear first, then set, so a new event is never lost
    if (do_wr && hit(avs_address, ECT_ICLR_OFS)) begin
      q_next.status = q_reg.status & ~avs_writedata[ECT_ST_W-1:0];
    end
    if (tc_hit) begin
      q_next.status[ECT_S_TC] = 1'b1;
    end
    if (gate_act && !q_reg.gate_d) begin
      q_next.status[ECT_S_GATE] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg        <= '0;
      q_reg.ctrl   <= ECT_CTRL_RST;
      q_reg.status <= ECT_ST_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // Output pin generator
  ect_outgen u_out (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .src_edge    (sel_edge),
    .tc_hit      (tc_hit),
    .toggle_mode (toggle_eff),
    .out_clr     (load_cmd),
    .pin         (pin_lvl)
  );

  assign cnt_out         = REDUCED ? ~pin_lvl : pin_lvl;
  assign terminal_count  = q_reg.tc_p;
  assign avs_readdata    = q_reg.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q_reg.ack;
  assign irq             = |(q_reg.status & q_reg.ien);

  // Checks below share the core clock and the released reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  count_hold_a: assert property (
    !cnt_edge && !load_cmd |=> $stable(q_reg.cnt))
    else $error("count changed without a counted edge");
  preload_a: assert property (
    load_cmd |=> q_reg.cnt == $past(q_reg.load))
    else $error("preload value not taken");
  step_up_a: assert property (
    cnt_edge && up && !load_cmd |=> q_reg.cnt == $past(q_reg.cnt) + CNT_W'(1))
    else $error("up count did not add one");
  step_down_a: assert property (
    cnt_edge && !up && !load_cmd |=> q_reg.cnt == $past(q_reg.cnt) - CNT_W'(1))
    else $error("down count did not subtract one");
  tc_value_a: assert property (
    tc_hit |=> (q_reg.cnt == '0) || (q_reg.cnt == {CNT_W{1'b1}}))
    else $error("terminal count at wrong value");
  gate_block_a: assert property (
    !cnt_ok && !load_cmd |=> q_reg.cnt == $past(q_reg.cnt))
    else $error("counted while gate closed or disarmed");
  tc_chain_a: assert property (
    tc_hit |=> terminal_count && q_reg.status[ECT_S_TC] ##1 !terminal_count)
    else $error("terminal count pulse or status wrong");
  // Bus answers after one wait
  bus_answer_a: assert property (
    (avs_read || avs_write) && !q_reg.ack |=> !avs_waitrequest)
    else $error("bus answer not in second cycle");
  // Writes land only in the answer cycle
  write_slot_a: assert property (
    do_wr |-> !avs_waitrequest)
    else $error("write took effect while the bus was stalled");
  src_only_a: assert property (
    !sel_edge && !load_cmd |=> q_reg.cnt == $past(q_reg.cnt))
    else $error("count moved without a source edge");
  dir_ctrl_a: assert property (
    !q_reg.ctrl[ECT_C_EXTDIR] && !REDUCED |-> up == q_reg.ctrl[ECT_C_UP])
    else $error("direction does not follow the control bit");
  soft_start_a: assert property (
    !q_reg.armed |-> !cnt_ok)
    else $error("counting allowed while disarmed");
  gate_shut_a: assert property (
    q_reg.ctrl[ECT_C_GATE] && !gate_act |-> !cnt_ok)
    else $error("counting allowed with the gate closed");
  out_pulse_a: assert property (
    tc_hit && !toggle_eff && !do_wr |=> pin_lvl)
    else $error("pulse output not raised at terminal count");
  tc_up_a: assert property (
    tc_hit && up |=> q_reg.cnt == {CNT_W{1'b1}})
    else $error("up terminal count not at all ones");
  tc_down_a: assert property (
    tc_hit && !up |=> q_reg.cnt == '0)
    else $error("down terminal count not at zero");
  fall_mode_a: assert property (
    q_reg.ctrl[ECT_C_FALL] && !REDUCED && !evt.src_fall |-> !cnt_edge)
    else $error("counted a rise in falling-edge mode");
  rise_mode_a: assert property (
    !q_reg.ctrl[ECT_C_FALL] && !evt.src_rise |-> !cnt_edge)
    else $error("counted a fall in rising-edge mode");
  ext_dir_a: assert property (
    q_reg.ctrl[ECT_C_EXTDIR] && !REDUCED |-> up == evt.dir_lvl)
    else $error("direction does not follow the external line");
  red_rise_a: assert property (
    REDUCED && !evt.src_rise |-> !cnt_edge)
    else $error("reduced variant counted a non-rising edge");
  red_down_a: assert property (
    REDUCED |-> !up)
    else $error("reduced variant counting up");
  red_gate_a: assert property (
    REDUCED && !evt.gate_lvl |-> !cnt_ok)
    else $error("reduced variant counting with gate low");
  red_low_a: assert property (
    REDUCED |-> cnt_out == !pin_lvl)
    else $error("reduced variant pulse not active low");
  edge_gap_a: assert property (
    cnt_edge |=> !cnt_edge)
    else $error("one transition counted twice");
  // Sticky status holds until cleared
  sticky_tc_a: assert property (
    q_reg.status[ECT_S_TC] && !(do_wr && hit(avs_address, ECT_ICLR_OFS))
      |=> q_reg.status[ECT_S_TC])
    else $error("terminal count status lost without a clear");
  // Enabled status raises the interrupt
  irq_level_a: assert property (
    q_reg.status[ECT_S_TC] && q_reg.ien[ECT_S_TC] |-> irq)
    else $error("interrupt low with an enabled status bit set");
endmodule

// File: verif/ect_src_model.sv
// Model of the external TTL lines: counted edge source, gate and direction.
// Assumes its tasks are called right after a rising edge of core_clk.
`timescale 1ns/10ps
module ect_src_model (
  input  wire logic core_clk,
  output logic      src_pin,
  output logic      gate_pin,
  output logic      dir_pin
);
  // TTL drivers always hold a level, so no released state here
  initial begin
    src_pin  = 1'b0;
    gate_pin = 1'b0;
    dir_pin  = 1'b1;
  end
  // Full source periods; 4 clocks high and at least 5 low, above the 2-clock minimum
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge core_clk);
      src_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      src_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    // Let the last falling edge reach the count
    repeat (4) @(posedge core_clk);
  endtask
  task automatic set_dir(input logic up);
    @(posedge core_clk);
    dir_pin <= up;
  endtask
  // Gate level, held until changed again
  task automatic set_gate(input logic lvl);
    @(posedge core_clk);
    gate_pin <= lvl;
    repeat (5) @(posedge core_clk);
  endtask
endmodule

// File: verif/edge_counter_timer_tb.sv
// Self-checking bench for the edge counter timer top.
// Assumes the default 32-bit full variant and the source model beside it.
`timescale 1ns/10ps
module edge_counter_timer_tb;
  import ect_pkg::*;
  logic        core_clk;       // 125 MHz clock
  logic        resetn;         // Active-low reset
  logic [4:0]  avs_address;    // Bus address
  logic        avs_read;       // Read request
  logic        avs_write;      // Write request
  logic [31:0] avs_writedata;  // Write data
  logic [31:0] avs_readdata;   // Read data
  logic        avs_waitrequest; // Slave stall
  logic        src_pin;        // Counted edge line
  logic        gate_pin;       // Gate line
  logic        dir_pin;        // Direction line
  logic        cnt_out;        // Output pin
  logic        terminal_count; // One-cycle terminal count pulse
  logic        irq;            // Level interrupt
  int          miscompares;    // Mismatches seen
  int          checks_done;    // Comparisons made
  int          tc_seen = 0;    // Terminal count pulses counted
  logic [31:0] rd_readdata;    // Reduced variant read data
  logic        rd_cnt_out;     // Reduced variant output pin
  logic [31:0] rdr_q;          // Reduced read data of the last access

  ect_top dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_pin(src_pin),
    .gate_pin(gate_pin), .dir_pin(dir_pin), .cnt_out(cnt_out),
    .terminal_count(terminal_count), .irq(irq));
  ect_src_model src (.core_clk(core_clk), .src_pin(src_pin), .gate_pin(gate_pin),
    .dir_pin(dir_pin));
  // Reduced 16-bit variant on the same bus and pins
  ect_top #(.CNT_W(16), .REDUCED(1'b1)) dut_r (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(rd_readdata), .avs_waitrequest(),
    .src_pin(src_pin), .gate_pin(gate_pin), .dir_pin(dir_pin), .cnt_out(rd_cnt_out),
    .terminal_count(), .irq());

  // Clock, 8 ns period
  always #4 core_clk = ~core_clk;
  // Count pulses; a stuck-high pulse shows up as too many
  always @(posedge core_clk) begin
    if (terminal_count === 1'b1) begin
      tc_seen <= tc_seen + 1;
    end
  end

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (exp !== got) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One bus access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    rdr_q = rd_readdata;
    if (n >= 20) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, exp, q);
  endtask

  // Reset values, read-only and write-only places, unmapped address
  task automatic t_regs;
    rd_chk("ctrl_rst", ECT_CTRL_OFS, 32'h0000_0000);
    rd_chk("count_rst", ECT_COUNT_OFS, 32'h0000_0000);
    rd_chk("stat_rst", ECT_STAT_OFS, 32'h0000_0000);
    wr(ECT_CTRL_OFS, 32'h0000_003F);
    rd_chk("ctrl_rw", ECT_CTRL_OFS, 32'h0000_003F);
    rd_chk("glow_evt", ECT_STAT_OFS, 32'h0000_0002);
    wr(ECT_ICLR_OFS, 32'h0000_0003);
    wr(ECT_LOAD_OFS, 32'hA5A5_0001);
    rd_chk("load_rw", ECT_LOAD_OFS, 32'hA5A5_0001);
    wr(ECT_COUNT_OFS, 32'h1234_5678);
    rd_chk("count_ro", ECT_COUNT_OFS, 32'h0000_0000);
    rd_chk("cmd_wo", ECT_CMD_OFS, 32'h0000_0000);
    wr(5'h02, 32'hFFFF_FFFF);
    rd_chk("unmapped", 5'h02, 32'h0000_0000);
  endtask
  // Up count through terminal count, pulse output, interrupt
  task automatic t_up_pulse;
    wr(ECT_CTRL_OFS, 32'h0000_0001);
    wr(ECT_LOAD_OFS, 32'hFFFF_FFFD);
    wr(ECT_IEN_OFS, 32'h0000_0001);
    wr(ECT_CMD_OFS, 32'h0000_0003);
    rd_chk("preload", ECT_COUNT_OFS, 32'hFFFF_FFFD);
    src.pulse(1);
    rd_chk("up_step", ECT_COUNT_OFS, 32'hFFFF_FFFE);
    rd_chk("reread", ECT_COUNT_OFS, 32'hFFFF_FFFE);
    chk("tc_early", 0, tc_seen);
    src.pulse(1);
    rd_chk("up_top", ECT_COUNT_OFS, 32'hFFFF_FFFF);
    chk("tc_up", 1, tc_seen);
    chk("pulse_hi", 1'b1, cnt_out);
    rd_chk("stat_tc", ECT_STAT_OFS, 32'h0000_0001);
    chk("irq_on", 1'b1, irq);
    wr(ECT_ICLR_OFS, 32'h0000_0001);
    // Clear lands at the answer edge; look once it has settled
    @(posedge core_clk);
    chk("irq_off", 1'b0, irq);
    src.pulse(1);
    rd_chk("wrap", ECT_COUNT_OFS, 32'h0000_0000);
    chk("pulse_end", 1'b0, cnt_out);
    chk("tc_once", 1, tc_seen);
  endtask
  // Falling edges, toggle output, direction from the external line
  task automatic t_fall_toggle;
    wr(ECT_CTRL_OFS, 32'h0000_0032);
    wr(ECT_LOAD_OFS, 32'h0000_0001);
    wr(ECT_CMD_OFS, 32'h0000_0003);
    src.set_dir(1'b0);
    src.pulse(1);
    rd_chk("down_zero", ECT_COUNT_OFS, 32'h0000_0000);
    chk("tgl_hi", 1'b1, cnt_out);
    src.set_dir(1'b1);
    src.pulse(1);
    rd_chk("ext_up", ECT_COUNT_OFS, 32'h0000_0001);
    chk("tgl_hold", 1'b1, cnt_out);
    src.set_dir(1'b0);
    src.pulse(1);
    rd_chk("ext_down", ECT_COUNT_OFS, 32'h0000_0000);
    chk("tgl_lo", 1'b0, cnt_out);
    chk("tc_down", 3, tc_seen);
  endtask
  // Gated counting, gate event, disarm beating arm
  task automatic t_gate;
    wr(ECT_ICLR_OFS, 32'h0000_0003);
    wr(ECT_CTRL_OFS, 32'h0000_0005);
    wr(ECT_LOAD_OFS, 32'h0000_000A);
    wr(ECT_CMD_OFS, 32'h0000_0003);
    src.pulse(2);
    rd_chk("gate_shut", ECT_COUNT_OFS, 32'h0000_000A);
    src.set_gate(1'b1);
    rd_chk("gate_evt", ECT_STAT_OFS, 32'h0000_0002);
    src.pulse(2);
    rd_chk("gate_open", ECT_COUNT_OFS, 32'h0000_000C);
    wr(ECT_CMD_OFS, 32'h0000_0006);
    src.pulse(1);
    rd_chk("disarmed", ECT_COUNT_OFS, 32'h0000_000C);
    src.set_gate(1'b0);
  endtask

  // Reduced variant: 16-bit load, forced high gate, down only, low pulse
  task automatic t_reduced;
    wr(ECT_CTRL_OFS, 32'h0000_0002);
    wr(ECT_LOAD_OFS, 32'h0001_0002);
    wr(ECT_CMD_OFS, 32'h0000_0003);
    rd_chk("load_32", ECT_LOAD_OFS, 32'h0001_0002);
    chk("load_16", 32'h0000_0002, rdr_q);
    chk("red_idle", 1'b1, rd_cnt_out);
    src.pulse(1);
    rd_chk("ungated", ECT_COUNT_OFS, 32'h0001_0001);
    chk("red_gated", 32'h0000_0002, rdr_q);
    src.set_gate(1'b1);
    src.pulse(2);
    rd_chk("cross_16", ECT_COUNT_OFS, 32'h0000_FFFF);
    chk("red_zero", 32'h0000_0000, rdr_q);
    chk("red_pulse", 1'b0, rd_cnt_out);
    src.pulse(1);
    rd_chk("dut_down", ECT_COUNT_OFS, 32'h0000_FFFE);
    chk("red_wrap", 32'h0000_FFFF, rdr_q);
    chk("red_end", 1'b1, rd_cnt_out);
    src.set_gate(1'b0);
  endtask
  // Mid-run reset restores reset values in both variants
  task automatic t_reset;
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("out_rst", 1'b0, cnt_out);
    chk("red_out_rst", 1'b1, rd_cnt_out);
    chk("irq_rst2", 1'b0, irq);
    rd_chk("ctrl_rst2", ECT_CTRL_OFS, 32'h0000_0000);
    rd_chk("count_rst2", ECT_COUNT_OFS, 32'h0000_0000);
    chk("red_cnt_rst", 32'h0000_0000, rdr_q);
  endtask

  // Counts, verdict, stop
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    chk("watchdog", 0, 1);
    end_sim();
  end
  // Main sequence
  initial begin
    core_clk      = 1'b0;
    resetn        = 1'b0;
    avs_address   = 5'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    miscompares   = 0;
    checks_done   = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("irq_rst", 1'b0, irq);
    t_regs();
    t_up_pulse();
    t_fall_toggle();
    t_gate();
    t_reduced();
    t_reset();
    end_sim();
  end
endmodule
